// ===== logic/irq_wake_pkg.sv
package irq_wake_pkg;

   // Register map, byte addresses on the 16-bit register port.
   localparam logic [15:0] ADDR_EXT_IRQ_ENABLE = 16'h0008;
   localparam logic [15:0] ADDR_MISC           = 16'h0009;
   localparam logic [15:0] ADDR_IRQ_STATUS     = 16'h000A;

   localparam logic [7:0]  EXT_IRQ_ENABLE_RST  = 8'h00;
   localparam int          SLOW_BIT            = 2;

   // Lines 3, 4, 7 and 8 react to a falling edge, the others to a rising edge.
   localparam logic [7:0]  FALLING_LINES       = 8'hCC;

   localparam int          OSC_DIV             = 3;
   localparam int          SLOW_DIV            = 2;
   localparam int          WAKE_CYCLES         = 4096;

   // Source indices, highest priority first.
   localparam int          SRC_RESET           = 0;
   localparam int          SRC_TRAP            = 1;
   localparam int          SRC_FLASH           = 2;
   localparam int          SRC_USB_END         = 3;
   localparam int          SRC_EXT             = 4;
   localparam int          SRC_TIMER           = 5;
   localparam int          SRC_RSVD            = 6;
   localparam int          SRC_SERIAL          = 7;
   localparam int          SRC_USB             = 8;
   localparam int          NUM_SRC             = 9;

   localparam logic [15:0] VEC_RESET           = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP            = 16'hFFFC;
   localparam logic [15:0] VEC_FLASH           = 16'hFFFA;
   localparam logic [15:0] VEC_USB_END         = 16'hFFF8;
   localparam logic [15:0] VEC_EXT             = 16'hFFF6;
   localparam logic [15:0] VEC_TIMER           = 16'hFFF4;
   localparam logic [15:0] VEC_RSVD            = 16'hFFF2;
   localparam logic [15:0] VEC_SERIAL          = 16'hFFF0;
   localparam logic [15:0] VEC_USB             = 16'hFFEE;

   typedef enum logic [3:0] {
      PWR_RUN   = 4'h1,
      PWR_WAIT  = 4'h2,
      PWR_HALT  = 4'h4,
      PWR_START = 4'h8
   } power_e;

endpackage

// ===== logic/irq_wake_power_control.sv
`timescale 1ns/100ps

// Function
// R1 - Reset, trap, flash start, USB end-suspend rank highest, with their vectors.
// R2 - Then external, timer, reserved, serial, general USB, the last lowest.
// R3 - Only enabled external lines, USB end-suspend or reset leave halt.
// R4 - Enable register at 0008h, reset 00h, bit n-1 enables line n.
// R5 - Lines 1, 2, 5, 6 request on a rising pin edge when enabled.
// R6 - Lines 3, 4, 7, 8 request on a falling pin edge when enabled.
// R7 - A disabled line never requests, whatever its pin does.
// R8 - Halt switches the oscillator off, stopping CPU and peripherals.
// R9 - Entering halt clears the interrupt mask bit.
// R10 - Halt wake restarts oscillator and stalls CPU for 4096 CPU clocks.
// R11 - After the delay the waking interrupt or reset vector is served.
// R12 - Servicing sets the mask bit; popping the condition code clears it.
// R13 - Slow select adds a divide-by-2 to the CPU and peripheral clock.
// R14 - Wait stops the CPU only and forces the mask bit to 0.
// R15 - Wait ends on any interrupt or reset with a vector fetch.
// R16 - After reset run mode with CPU clock equal to oscillator over 3; the code resets into PWR_START and stalls the CPU for the wake delay first.
// R17 - Enabled pins of one vector are ORed; an active pin masks others.
// R18 - A pin in output mode cannot raise an external interrupt.
// R19 - Each enabled input pin is qualified independently of the others.
// R20 - Software keeps alternate functions off pins used as interrupt inputs.
// R21 - With several pending, the highest priority is presented first.
// R22 - A masked request stays pending until it can be served.
// R23 - Pins pass two flip-flops; sample compare sets a pending latch.
// R24 - Wake delay counts restarted CPU clocks, CPU stalled until terminal.
module irq_wake_power_control #(
   parameter int WAKE_CYCLES = irq_wake_pkg::WAKE_CYCLES,
   parameter int LINES       = 8
) (
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   input  wire logic [15:0]       reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [7:0]        reg_rdata_o,
   input  wire logic [LINES-1:0]  ext_irq_line_i,
   input  wire logic [LINES-1:0]  pin_dir_i,
   input  wire logic              timer_status_i,
   input  wire logic              serial_status_i,
   input  wire logic              usb_irq_status_i,
   input  wire logic              usb_suspend_end_i,
   input  wire logic              flash_prog_start_i,
   input  wire logic              trap_instr_i,
   input  wire logic              halt_instr_i,
   input  wire logic              wait_for_interrupt_instr_i,
   input  wire logic              cc_pop_i,
   input  wire logic              irq_ack_i,
   output logic                   irq_req_o,
   output logic      [15:0]       irq_vector_o,
   output logic                   irq_mask_o,
   output logic                   osc_enable_o,
   output logic                   cpu_stall_o,
   output logic                   cpu_tick_o
);

   localparam int CW = $clog2(WAKE_CYCLES);
   localparam logic [CW-1:0] WAKE_LAST = CW'(WAKE_CYCLES - 1);
   localparam logic [2:0] DIV_LAST = 3'(irq_wake_pkg::OSC_DIV - 1);
   localparam logic [2:0] SLOW_LAST = 3'(irq_wake_pkg::OSC_DIV * irq_wake_pkg::SLOW_DIV - 1);

   irq_wake_pkg::power_e state_q;
   logic [7:0]           enable_q;
   logic                 slow_q;
   logic [LINES-1:0]     sync1_q;
   logic [LINES-1:0]     sync2_q;
   logic                 group_q;
   logic                 group_d;
   logic                 pend_ext_q;
   logic                 pend_reset_q;
   logic                 pend_trap_q;
   logic                 pend_flash_q;
   logic                 pend_usb_end_q;
   logic [irq_wake_pkg::NUM_SRC-1:0] pend;
   logic [irq_wake_pkg::NUM_SRC-1:0] elig;
   logic [3:0]           sel_d;
   logic [3:0]           sel_q;
   logic                 any_elig;
   logic [15:0]          vector_d;
   logic                 mask_q;
   logic [2:0]           div_q;
   logic [2:0]           div_last;
   logic                 tick_q;
   logic [CW-1:0]        wake_cnt_q;
   logic                 wake_done;
   logic                 halt_wake;
   logic                 ack_ext;
   logic                 run_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Register port.

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enable_q <= irq_wake_pkg::EXT_IRQ_ENABLE_RST;
      end else if (reg_wr_i && reg_addr_i == irq_wake_pkg::ADDR_EXT_IRQ_ENABLE) begin
         enable_q <= reg_wdata_i; // [R4]
      end
   end

   // Slow select can only be set by software; only reset clears it.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         slow_q <= 1'b0;
      end else if (reg_wr_i && reg_addr_i == irq_wake_pkg::ADDR_MISC &&
                   reg_wdata_i[irq_wake_pkg::SLOW_BIT]) begin
         slow_q <= 1'b1; // [R13]
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            irq_wake_pkg::ADDR_EXT_IRQ_ENABLE: reg_rdata_o <= enable_q;
            irq_wake_pkg::ADDR_MISC: reg_rdata_o <= {5'h00, slow_q, 2'h0};
            irq_wake_pkg::ADDR_IRQ_STATUS: reg_rdata_o <= {2'h0, cpu_stall_o, mask_q,
                                                           pend_flash_q, pend_trap_q,
                                                           pend_usb_end_q, pend_ext_q};
            default: reg_rdata_o <= 8'h00;
         endcase
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // External lines.

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // Reset to the idle level, so an armed falling line sees no edge on release.
         sync1_q <= irq_wake_pkg::FALLING_LINES[LINES-1:0];
         sync2_q <= irq_wake_pkg::FALLING_LINES[LINES-1:0];
      end else begin
         sync1_q <= ext_irq_line_i; // [R23]
         sync2_q <= sync1_q;
      end
   end

   // Each line is normalised to active high and qualified on its own, then the
   // group is ORed, so a line held active hides edges on its neighbours.
   always_comb begin
      group_d = 1'b0;
      for (int i = 0; i < LINES; i++) begin
         if (enable_q[i] && !pin_dir_i[i] && // [R7] [R18] [R19]
             (sync2_q[i] ^ irq_wake_pkg::FALLING_LINES[i])) begin // [R5] [R6]
            group_d = 1'b1; // [R17]
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         group_q <= 1'b0;
      end else begin
         group_q <= group_d; // [R23]
      end
   end

   assign ack_ext = irq_ack_i && sel_q == 4'(irq_wake_pkg::SRC_EXT);

   // The edge wins over a clear that lands in the same cycle.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_ext_q <= 1'b0;
      end else if (group_d && !group_q) begin
         pend_ext_q <= 1'b1; // [R22] [R23]
      end else if (ack_ext) begin
         pend_ext_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Event latches for the upper sources; peripheral flags are levels held in
   // their own status registers and are only sampled here.

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_reset_q <= 1'b1;
      end else if (irq_ack_i && sel_q == 4'(irq_wake_pkg::SRC_RESET)) begin
         pend_reset_q <= 1'b0; // [R11]
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_trap_q <= 1'b0;
      end else if (trap_instr_i) begin
         pend_trap_q <= 1'b1;
      end else if (irq_ack_i && sel_q == 4'(irq_wake_pkg::SRC_TRAP)) begin
         pend_trap_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_flash_q <= 1'b0;
      end else if (flash_prog_start_i) begin
         pend_flash_q <= 1'b1;
      end else if (irq_ack_i && sel_q == 4'(irq_wake_pkg::SRC_FLASH)) begin
         pend_flash_q <= 1'b0;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_usb_end_q <= 1'b0;
      end else if (usb_suspend_end_i) begin
         pend_usb_end_q <= 1'b1;
      end else if (irq_ack_i && sel_q == 4'(irq_wake_pkg::SRC_USB_END)) begin
         pend_usb_end_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Priority and vector.

   assign pend = {usb_irq_status_i, serial_status_i, 1'b0, timer_status_i, pend_ext_q,
                  pend_usb_end_q, pend_flash_q, pend_trap_q, pend_reset_q};

   // Reset and trap ignore the mask; everything else waits for it to drop.
   assign elig = pend & {{(irq_wake_pkg::NUM_SRC-2){!mask_q}}, 2'b11}; // [R22]
   assign any_elig = |elig;

   always_comb begin
      sel_d = 4'(irq_wake_pkg::SRC_USB);
      for (int i = irq_wake_pkg::NUM_SRC - 1; i >= 0; i--) begin
         if (elig[i]) begin
            sel_d = 4'(i); // [R21]
         end
      end
   end

   always_comb begin
      unique case (sel_d)
         4'(irq_wake_pkg::SRC_RESET):   vector_d = irq_wake_pkg::VEC_RESET; // [R1]
         4'(irq_wake_pkg::SRC_TRAP):    vector_d = irq_wake_pkg::VEC_TRAP;
         4'(irq_wake_pkg::SRC_FLASH):   vector_d = irq_wake_pkg::VEC_FLASH;
         4'(irq_wake_pkg::SRC_USB_END): vector_d = irq_wake_pkg::VEC_USB_END;
         4'(irq_wake_pkg::SRC_EXT):     vector_d = irq_wake_pkg::VEC_EXT; // [R2]
         4'(irq_wake_pkg::SRC_TIMER):   vector_d = irq_wake_pkg::VEC_TIMER;
         4'(irq_wake_pkg::SRC_RSVD):    vector_d = irq_wake_pkg::VEC_RSVD;
         4'(irq_wake_pkg::SRC_SERIAL):  vector_d = irq_wake_pkg::VEC_SERIAL;
         default:                       vector_d = irq_wake_pkg::VEC_USB;
      endcase
   end

   // A request is raised only from run mode, but being registered it can stay up for one cycle after halt or wait entry.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_req_o    <= 1'b0;
         irq_vector_o <= irq_wake_pkg::VEC_RESET;
         sel_q        <= 4'(irq_wake_pkg::SRC_RESET);
      end else begin
         irq_req_o    <= run_q && any_elig && !irq_ack_i; // [R11] [R15]
         irq_vector_o <= vector_d;
         sel_q        <= sel_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt mask bit.

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mask_q <= 1'b1;
      end else if (run_q && (halt_instr_i || wait_for_interrupt_instr_i)) begin
         mask_q <= 1'b0; // [R9] [R14]
      end else if (irq_ack_i) begin
         mask_q <= 1'b1; // [R12]
      end else if (cc_pop_i) begin
         mask_q <= 1'b0; // [R12]
      end
   end

   assign irq_mask_o = mask_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock divider and power modes.

   assign div_last = slow_q ? SLOW_LAST : DIV_LAST; // [R13] [R16]

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_q  <= 3'h0;
         tick_q <= 1'b0;
      end else if (!osc_enable_o || (run_q && halt_instr_i)) begin
         // The oscillator stops on the halt entry edge, so no tick may leave on it.
         div_q  <= 3'h0; // [R8]
         tick_q <= 1'b0;
      end else begin
         div_q  <= (div_q >= div_last) ? 3'h0 : div_q + 3'h1;
         tick_q <= div_q >= div_last;
      end
   end

   assign cpu_tick_o = tick_q;

   // The stabilisation counter runs on restarted CPU clock ticks, so the delay
   // stretches to twice the time in slow mode.
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wake_cnt_q <= '0;
      end else if (state_q != irq_wake_pkg::PWR_START) begin
         wake_cnt_q <= '0;
      end else if (tick_q && wake_cnt_q != WAKE_LAST) begin
         wake_cnt_q <= wake_cnt_q + CW'(1); // [R24]
      end
   end

   assign wake_done = tick_q && wake_cnt_q == WAKE_LAST; // [R10]
   assign halt_wake = pend_ext_q || pend_usb_end_q; // [R3]

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= irq_wake_pkg::PWR_START;
      end else begin
         unique case (state_q)
            irq_wake_pkg::PWR_RUN: begin
               if (halt_instr_i) begin
                  state_q <= irq_wake_pkg::PWR_HALT; // [R8]
               end else if (wait_for_interrupt_instr_i) begin
                  state_q <= irq_wake_pkg::PWR_WAIT; // [R14]
               end
            end
            irq_wake_pkg::PWR_WAIT: begin
               if (any_elig) begin
                  state_q <= irq_wake_pkg::PWR_RUN; // [R15]
               end
            end
            irq_wake_pkg::PWR_HALT: begin
               if (halt_wake) begin
                  state_q <= irq_wake_pkg::PWR_START; // [R3] [R10]
               end
            end
            irq_wake_pkg::PWR_START: begin
               if (wake_done) begin
                  state_q <= irq_wake_pkg::PWR_RUN; // [R24]
               end
            end
         endcase
      end
   end

   assign run_q        = state_q == irq_wake_pkg::PWR_RUN;
   assign osc_enable_o = state_q != irq_wake_pkg::PWR_HALT; // [R8]
   assign cpu_stall_o  = !run_q; // [R10] [R14]

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   AST_DISABLED_QUIET: assert property (enable_q == 8'h00 && !pend_ext_q |=> !pend_ext_q) // [R7]
      else $error("external pending set with all lines disabled");
   AST_HALT_OSC_OFF: assert property (state_q == irq_wake_pkg::PWR_HALT |-> !osc_enable_o && !tick_q) // [R8]
      else $error("oscillator running in halt");
   AST_HALT_CLEARS_MASK: assert property (run_q && halt_instr_i |=> !mask_q && state_q == irq_wake_pkg::PWR_HALT) // [R9]
      else $error("halt entry did not clear the mask");
   AST_HALT_NO_WAKE: assert property (state_q == irq_wake_pkg::PWR_HALT && !halt_wake |=> state_q == irq_wake_pkg::PWR_HALT) // [R3]
      else $error("left halt without a wake source");
   AST_WAKE_EARLY: assert property (state_q == irq_wake_pkg::PWR_START && wake_cnt_q != WAKE_LAST |=> !run_q) // [R10]
      else $error("CPU released before the stabilisation count");
   AST_WAKE_RELEASE: assert property (state_q == irq_wake_pkg::PWR_START && wake_done |=> run_q) // [R24]
      else $error("CPU not released at terminal count");
   AST_ACK_SETS_MASK: assert property (irq_ack_i && !(run_q && halt_instr_i) && !(run_q && wait_for_interrupt_instr_i) |=> mask_q) // [R12]
      else $error("mask not set on service");
   AST_WAIT_ENTRY: assert property (run_q && wait_for_interrupt_instr_i && !halt_instr_i |=> state_q == irq_wake_pkg::PWR_WAIT && !mask_q) // [R14]
      else $error("wait entry wrong");
   AST_WAIT_EXIT: assert property (state_q == irq_wake_pkg::PWR_WAIT && any_elig |=> run_q ##1 irq_req_o || $past(irq_ack_i)) // [R15]
      else $error("wait not left on interrupt");
   AST_TRAP_FIRST: assert property (irq_req_o && !pend_reset_q && $past(pend_trap_q) && $past(!irq_ack_i) |-> irq_vector_o == irq_wake_pkg::VEC_TRAP) // [R21]
      else $error("trap not presented first");
   AST_TICK_SPACING: assert property (tick_q && !slow_q |=> !tick_q [*2]) // [R16]
      else $error("CPU clock faster than oscillator over 3");
   AST_SLOW_SPACING: assert property (tick_q && slow_q |=> !tick_q [*5]) // [R13]
      else $error("slow clock not halved");

   COV_HALT_WAKE: cover property (state_q == irq_wake_pkg::PWR_HALT ##1 state_q == irq_wake_pkg::PWR_START);
   COV_WAIT_EXIT: cover property (state_q == irq_wake_pkg::PWR_WAIT ##1 run_q);
   COV_EXT_SERVED: cover property (irq_req_o && irq_vector_o == irq_wake_pkg::VEC_EXT && irq_ack_i);

endmodule // irq_wake_power_control

// ===== verification/cpu_model.sv
`timescale 1ns/100ps

// Stands in for the core: takes a presented vector after a chosen delay, runs a short
// service routine and returns with a condition-code pop, so masking is exercised.
module cpu_model (
   input  wire logic       clock_i,
   input  wire logic       rst_n_i,
   input  wire logic [3:0] ack_delay_i,
   input  wire logic       irq_req_i,
   output logic            irq_ack_o,
   output logic            cc_pop_o
);
   logic       busy_q;
   logic [3:0] cnt_q;

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_q    <= 1'b0;
         cnt_q     <= 4'h0;
         irq_ack_o <= 1'b0;
         cc_pop_o  <= 1'b0;
      end else begin
         irq_ack_o <= 1'b0;
         cc_pop_o  <= 1'b0;
         if (busy_q) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == 4'h6) begin
               cc_pop_o <= 1'b1;
               busy_q   <= 1'b0;
               cnt_q    <= 4'h0;
            end
         end else if (irq_req_i) begin
            if (cnt_q >= ack_delay_i) begin
               irq_ack_o <= 1'b1;
               busy_q    <= 1'b1;
               cnt_q     <= 4'h0;
            end else begin
               cnt_q <= cnt_q + 4'h1;
            end
         end else begin
            cnt_q <= 4'h0;
         end
      end
   end
endmodule // cpu_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

module testbench;
   localparam int WAKE = 8;
   logic        clock_i, rst_n_i, wr, rd, timer, serial, usb, usb_end, flash, trap, halt, wait_for_interrupt_instr;
   logic        rd_seen;
   logic [15:0] addr, e16;
   logic [7:0]  wdata, ext, dir, b, r, e8;
   logic [3:0]  ack_dly;
   wire logic   req, mask, osc, stall, tick, ack, pop;
   wire logic [7:0]  rdata;
   wire logic [15:0] vec;
   int          miscompares, samples_checked, seed, cycles, n, g;
   logic [15:0] exp_vec[$];
   logic [7:0]  exp_rd[$];

   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   irq_wake_power_control #(.WAKE_CYCLES(WAKE)) i_irq_wake_power_control (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_irq_line_i(ext),
      .pin_dir_i(dir), .timer_status_i(timer), .serial_status_i(serial),
      .usb_irq_status_i(usb), .usb_suspend_end_i(usb_end), .flash_prog_start_i(flash),
      .trap_instr_i(trap), .halt_instr_i(halt), .wait_for_interrupt_instr_i(wait_for_interrupt_instr),
      .cc_pop_i(pop), .irq_ack_i(ack), .irq_req_o(req), .irq_vector_o(vec),
      .irq_mask_o(mask), .osc_enable_o(osc), .cpu_stall_o(stall), .cpu_tick_o(tick));

   cpu_model i_cpu_model (.clock_i(clock_i), .rst_n_i(rst_n_i), .ack_delay_i(ack_dly),
      .irq_req_i(req), .irq_ack_o(ack), .cc_pop_o(pop));

   ////////////////////////////////////////////////////////////////////////////////
   // Results are compared in the order the stimulus noted them.
   always @(posedge clock_i) begin
      if (rd_seen) begin
         e8 = exp_rd.pop_front();
         `CHECK(rdata, e8)
      end
      rd_seen <= rd;
      if (ack && req) begin
         e16 = (exp_vec.size() > 0) ? exp_vec.pop_front() : 16'h0000;
         `CHECK(vec, e16)
         // The peripheral clears its own level once the core has taken it.
         if (vec === irq_wake_pkg::VEC_TIMER) timer <= 1'b0;
         if (vec === irq_wake_pkg::VEC_SERIAL) serial <= 1'b0;
         if (vec === irq_wake_pkg::VEC_USB) usb <= 1'b0;
      end
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   task automatic tk(int k);
      repeat (k) @(posedge clock_i);
   endtask

   task automatic wreg(logic [15:0] a, logic [7:0] d);
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask

   task automatic rreg(logic [15:0] a, logic [7:0] e);
      @(posedge clock_i);
      exp_rd.push_back(e);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
   endtask

   task automatic toggle(logic [7:0] m);
      @(posedge clock_i);
      ext <= ext ^ m;
      tk(8);
   endtask

   task automatic drain;
      for (int i = 0; i < 600 && exp_vec.size() != 0; i++) @(posedge clock_i);
      `CHECK(exp_vec.size(), 0)
      tk(20);
   endtask

   task automatic gap(output int c);
      for (int i = 0; i < 20 && !tick; i++) @(negedge clock_i);
      @(negedge clock_i);
      c = 1;
      while (!tick && c < 20) begin
         @(negedge clock_i);
         c++;
      end
   endtask

   task test_done;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {wr, rd, timer, serial, usb, usb_end, flash, trap, halt, wait_for_interrupt_instr, rd_seen} = '0;
      {addr, wdata, dir, ack_dly, rst_n_i} = '0;
      ext  = irq_wake_pkg::FALLING_LINES;
      seed = 32'h95C2;
      tk(2);
      rst_n_i <= 1'b1;
      rreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, 8'h00);
      rreg(16'h0010, 8'h00);
      r = 8'($random(seed));
      ack_dly <= {2'b00, r[1:0]};
      wreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, r);
      rreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, r);
      gap(g);
      `CHECK(g, irq_wake_pkg::OSC_DIV)
      exp_vec.push_back(irq_wake_pkg::VEC_RESET);
      drain();
      wreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, 8'h00);
      // Only the direction of a pin is ever changed, never an alternate function.
      for (n = 0; n < 8; n++) begin
         b = 8'h01 << n;
         toggle(b);
         toggle(b);
         wreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, b);
         dir <= b;
         toggle(b);
         toggle(b);
         dir <= 8'h00;
         exp_vec.push_back(irq_wake_pkg::VEC_EXT);
         toggle(b);
         toggle(b);
         drain();
      end
      wreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, 8'h03);
      exp_vec.push_back(irq_wake_pkg::VEC_EXT);
      toggle(8'h01);
      drain();
      toggle(8'h02);
      toggle(8'h02);
      toggle(8'h01);
      tk(20);
      // Every source but reset, reserved and the external lines at once, with a slow core so the masked ones queue up.
      ack_dly <= 4'h5;
      {trap, flash, usb_end, timer, serial, usb} <= 6'h3F;
      exp_vec = '{16'hFFFC, 16'hFFFA, 16'hFFF8, 16'hFFF4, 16'hFFF0, 16'hFFEE};
      @(posedge clock_i);
      {trap, flash, usb_end} <= 3'h0;
      drain();
      wreg(irq_wake_pkg::ADDR_EXT_IRQ_ENABLE, 8'h01);
      halt  <= 1'b1;
      @(posedge clock_i);
      halt  <= 1'b0;
      timer <= 1'b1;
      tk(2);
      @(negedge clock_i);
      `CHECK({osc, mask, stall}, 3'b001)
      tk(20);
      @(negedge clock_i);
      `CHECK(osc, 1'b0)
      exp_vec = '{irq_wake_pkg::VEC_EXT, irq_wake_pkg::VEC_TIMER};
      @(posedge clock_i);
      ext <= ext ^ 8'h01;
      for (g = 0; g < 20 && !osc; g++) @(negedge clock_i);
      for (g = 0; g < 60 && stall; g++) @(negedge clock_i);
      `CHECK((g >= WAKE * 3) && (g <= WAKE * 3 + 4), 1'b1)
      toggle(8'h01);
      drain();
      trap <= 1'b1;
      exp_vec.push_back(irq_wake_pkg::VEC_TRAP);
      @(posedge clock_i);
      trap <= 1'b0;
      while (exp_vec.size() != 0) @(posedge clock_i);
      wait_for_interrupt_instr <= 1'b1;
      @(posedge clock_i);
      wait_for_interrupt_instr <= 1'b0;
      tk(2);
      @(negedge clock_i);
      `CHECK({osc, mask, stall}, 3'b101)
      rreg(irq_wake_pkg::ADDR_IRQ_STATUS, 8'h20);
      exp_vec.push_back(irq_wake_pkg::VEC_SERIAL);
      serial <= 1'b1;
      drain();
      wreg(irq_wake_pkg::ADDR_MISC, 8'h04);
      rreg(irq_wake_pkg::ADDR_MISC, 8'h04);
      gap(g);
      `CHECK(g, irq_wake_pkg::OSC_DIV * irq_wake_pkg::SLOW_DIV)
      test_done();
   end
endmodule // testbench
